// *** src/regen_sup_consts.vh ***
`ifndef REGEN_SUP_CONSTS_VH
`define REGEN_SUP_CONSTS_VH
// clock and timing figures
`define CLK_HZ 200000000
`define CLK_KHZ 200000
`define FAST_PER_S 3
`define SLOW_PER_S 1
`define T_PRECHARGE_MS 10000
`define T_READY_MS 2000
`define T_PAUSE_MS 2000
// fault bit positions, fast codes first
`define NFAULT 11
`define F_FBUV 0
`define F_OT 1
`define F_DCOV 2
`define F_DIFF 3
`define F_SYNC 4
`define F_DRV 5
`define F_OC 6
`define F_PLOSS 7
`define F_DCUV 8
`define F_PRE 9
`define F_FREQ 10
`define F_FAST_LAST 4'h4
`define F_NONE 4'hF
// pin input positions
`define NIN 16
`define I_FB 0
`define I_OT 1
`define I_DCOV 2
`define I_DIFF 3
`define I_SYNC 4
`define I_SYNCX 5
`define I_DRV 6
`define I_OC0 7
`define I_OC2 9
`define I_PLOSS 10
`define I_DCUV 11
`define I_FREQ 12
`define I_EN 13
`define I_RCL 14
`define I_RA 15
// register byte addresses
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_LAST 8'h08
`define A_HSEL 8'h0C
`define A_HFLT 8'h10
`define A_HTIM 8'h14
`define A_HCNT 8'h18
`define A_ELIF 8'h1C
`define A_EUSR 8'h20
`define A_UPT 8'h24
`define C_DISP 0
`define C_ERST 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define HIST_DEPTH 50
`endif

// *** src/blink_seq.v ***
`timescale 1ns/1ps
`default_nettype none
module blink_seq #(
  parameter [31:0] HALF_FAST = 32'd33333333,
  parameter [31:0] HALF_SLOW = 32'd100000000,
  parameter [31:0] PAUSE = 32'd400000000
) (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire fast,
  input wire [2:0] count,
  output reg led_r,
  output reg done_r
);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_ON = 2'd1;
  localparam [1:0] S_OFF = 2'd2;
  localparam [1:0] S_GAP = 2'd3;
  reg [1:0] state_r;
  reg [31:0] timer_r;
  reg [2:0] left_r;
  reg fast_r;
  wire [31:0] half = fast_r ? HALF_FAST : HALF_SLOW;
  // flash train: on half, off half, then a long dark gap
  always @(posedge aclk) begin
    done_r <= 1'b0;
    if (!aresetn || !run) begin
      state_r <= S_IDLE;
      timer_r <= 32'h0;
      left_r <= 3'h0;
      fast_r <= 1'b0;
      led_r <= 1'b0;
    end else if (state_r != S_IDLE && timer_r != 32'h0) begin
      timer_r <= timer_r - 32'h1;
    end else begin
      case (state_r)
        S_IDLE: begin
          fast_r <= fast;
          left_r <= count;
          timer_r <= (fast ? HALF_FAST : HALF_SLOW) - 32'h1;
          led_r <= 1'b1;
          state_r <= S_ON;
        end
        S_ON: begin
          led_r <= 1'b0;
          timer_r <= half - 32'h1;
          state_r <= S_OFF;
        end
        S_OFF: begin
          if (left_r <= 3'h1) begin
            timer_r <= PAUSE - 32'h1;
            state_r <= S_GAP;
          end else begin
            left_r <= left_r - 3'h1;
            led_r <= 1'b1;
            timer_r <= half - 32'h1;
            state_r <= S_ON;
          end
        end
        default: begin
          done_r <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // blink_seq
`default_nettype wire

// *** src/fault_history.v ***
`timescale 1ns/1ps
`default_nettype none
`include "regen_sup_consts.vh"
module fault_history (
  input wire aclk,
  input wire aresetn,
  input wire push,
  input wire [`NFAULT-1:0] push_fault,
  input wire [31:0] push_time,
  input wire [5:0] sel,
  output wire [`NFAULT-1:0] rd_fault,
  output wire [31:0] rd_time,
  output reg [5:0] count_r
);
  localparam [6:0] DEPTH = `HIST_DEPTH;
  reg [`NFAULT-1:0] flt_mem [0:`HIST_DEPTH-1];
  reg [31:0] tim_mem [0:`HIST_DEPTH-1];
  reg [5:0] ptr_r;
  // ring store; the oldest entry is overwritten when full
  always @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= 6'h0;
      count_r <= 6'h0;
    end else if (push) begin
      flt_mem[ptr_r] <= push_fault;
      tim_mem[ptr_r] <= push_time;
      ptr_r <= (ptr_r == DEPTH[5:0] - 6'h1) ? 6'h0 : ptr_r + 6'h1;
      if (count_r != DEPTH[5:0]) begin
        count_r <= count_r + 6'h1;
      end
    end
  end
  // index 0 is the newest entry
  wire [6:0] raw = {1'b0, ptr_r} + DEPTH - 7'h1 - {1'b0, sel};
  wire [6:0] phys = (raw >= DEPTH) ? raw - DEPTH : raw;
  wire hit = sel < count_r;
  assign rd_fault = hit ? flt_mem[phys[5:0]] : {`NFAULT{1'b0}};
  assign rd_time = hit ? tim_mem[phys[5:0]] : 32'h0;
endmodule // fault_history
`default_nettype wire

// *** src/regen_fault_supervisor.v ***
// Function
// - no display: red off in normal run, solid while enable is off.
// - no display: any fault flashes red with the active fault's code.
// - fast codes at three flashes a second, slow at one a second.
// - latching faults hold until enable toggles; others clear themselves.
// - ready contact opens on any fault, latched or not.
// - disabled plus recall input replays last fault state's codes in turn.
// - display units keep the 50 latest fault states with timestamps.
// - display units light red on any fault or enable off.
// - bus feedback failure latches, one fast flash.
// - overtemperature self-clears, two fast flashes.
// - absolute bus overvoltage latches, three fast flashes.
// - differential overvoltage latches, four fast flashes.
// - sync loss self-clears if regained, else latches; five fast flashes.
// - transistor driver error latches, one slow flash.
// - leg overcurrent on any of three legs latches, two slow flashes.
// - phase voltage loss self-clears, three slow flashes.
// - bus undervoltage self-clears, four slow flashes.
// - power-on precharge fault held ten seconds, five slow flashes.
// - line frequency detect failure holds until power off, six slow.
// - yellow lit while returning energy to the line; the code lights it only while enable is on and no fault is set.
// - green lit whenever powered.
// - lifetime energy total never zeroed; user total zeroed on request.
// - enable rising edge clears latches; no operation while disabled.
// - ready closes after two seconds enabled with no fault.
// - recall replay runs until enable returns.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "regen_sup_consts.vh"
module regen_fault_supervisor #(
  parameter [31:0] PRECHARGE_CYC = `T_PRECHARGE_MS * `CLK_KHZ,
  parameter [31:0] READY_CYC = `T_READY_MS * `CLK_KHZ,
  parameter [31:0] PAUSE_CYC = `T_PAUSE_MS * `CLK_KHZ,
  parameter [31:0] HALF_FAST_CYC = `CLK_HZ / (2 * `FAST_PER_S),
  parameter [31:0] HALF_SLOW_CYC = `CLK_HZ / (2 * `SLOW_PER_S),
  parameter [31:0] SEC_CYC = `CLK_HZ
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire fb_fail_in,
  input wire over_temp_in,
  input wire dc_over_in,
  input wire diff_over_in,
  input wire sync_lost_in,
  input wire sync_giveup_in,
  input wire drv_err_in,
  input wire [2:0] leg_oc_in,
  input wire phase_loss_in,
  input wire dc_under_in,
  input wire freq_fail_in,
  input wire enable_in,
  input wire recall_in,
  input wire regen_busy_in,
  input wire energy_tick,
  output reg ready_contact_r,
  output reg run_permit_r,
  output reg led_red_r,
  output reg led_yellow_r,
  output reg led_green_r
);
  // pin inputs gathered for synchronising
  wire [`NIN-1:0] pins = {regen_busy_in, recall_in, enable_in, freq_fail_in,
    dc_under_in, phase_loss_in, leg_oc_in, drv_err_in, sync_giveup_in,
    sync_lost_in, diff_over_in, dc_over_in, over_temp_in, fb_fail_in};
  reg [`NIN-1:0] s1_r;
  reg [`NIN-1:0] s2_r;
  reg [`NIN-1:0] s3_r;
  reg [`NIN-1:0] in_r;
  // three stages; a bit moves only when stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= {`NIN{1'b0}};
      s2_r <= {`NIN{1'b0}};
      s3_r <= {`NIN{1'b0}};
      in_r <= {`NIN{1'b0}};
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      in_r <= (s2_r & s3_r) | (in_r & (s2_r ^ s3_r));
    end
  end

  wire en = in_r[`I_EN];
  reg en_d_r;
  reg rcl_act_r;
  reg rcl_act_d_r;
  reg disp_r;
  reg erst_r;
  reg [5:0] hsel_r;
  wire clr = en & ~en_d_r;

  // precharge timer from power-on
  reg [31:0] pre_cnt_r;
  reg pre_busy_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= 32'h0;
      pre_busy_r <= 1'b1;
    end else if (pre_busy_r) begin
      if (pre_cnt_r >= PRECHARGE_CYC - 32'h1) begin
        pre_busy_r <= 1'b0;
      end else begin
        pre_cnt_r <= pre_cnt_r + 32'h1;
      end
    end
  end

  // latched faults: set beats a same-cycle clear
  reg [`NFAULT-1:0] lat_r;
  reg [`NFAULT-1:0] set_v;
  reg [`NFAULT-1:0] selfc_v;
  always @* begin
    set_v = {`NFAULT{1'b0}};
    selfc_v = {`NFAULT{1'b0}};
    set_v[`F_FBUV] = in_r[`I_FB];
    set_v[`F_DCOV] = in_r[`I_DCOV];
    set_v[`F_DIFF] = in_r[`I_DIFF];
    set_v[`F_SYNC] = in_r[`I_SYNCX];
    set_v[`F_DRV] = in_r[`I_DRV];
    set_v[`F_OC] = |in_r[`I_OC2:`I_OC0];
    set_v[`F_FREQ] = in_r[`I_FREQ];
    selfc_v[`F_OT] = in_r[`I_OT];
    selfc_v[`F_SYNC] = in_r[`I_SYNC];
    selfc_v[`F_PLOSS] = in_r[`I_PLOSS];
    selfc_v[`F_DCUV] = in_r[`I_DCUV];
    selfc_v[`F_PRE] = pre_busy_r;
  end

  // frequency bit is exempt from the enable clear: only reset drops it
  wire [`NFAULT-1:0] clr_mask = {1'b0, {(`NFAULT-1){clr}}};
  reg [`NFAULT-1:0] flt_r;
  wire any = |flt_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      lat_r <= {`NFAULT{1'b0}};
      flt_r <= {`NFAULT{1'b0}};
    end else begin
      lat_r <= (lat_r & ~clr_mask) | set_v;
      flt_r <= lat_r | selfc_v;
    end
  end

  // seconds since power-on for timestamps
  reg [31:0] sec_div_r;
  reg [31:0] uptime_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sec_div_r <= 32'h0;
      uptime_r <= 32'h0;
    end else if (sec_div_r >= SEC_CYC - 32'h1) begin
      sec_div_r <= 32'h0;
      uptime_r <= uptime_r + 32'h1;
    end else begin
      sec_div_r <= sec_div_r + 32'h1;
    end
  end

  // most recent fault state: all faults seen while any stays set
  reg any_d_r;
  reg [`NFAULT-1:0] last_r;
  reg [31:0] stamp_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      any_d_r <= 1'b0;
      last_r <= {`NFAULT{1'b0}};
      stamp_r <= 32'h0;
    end else begin
      any_d_r <= any;
      if (any) begin
        last_r <= (any_d_r ? last_r : {`NFAULT{1'b0}}) | flt_r;
      end
      if (any && !any_d_r) begin
        stamp_r <= uptime_r;
      end
    end
  end

  wire hist_push = any_d_r & ~any & disp_r;
  wire [`NFAULT-1:0] h_flt;
  wire [31:0] h_tim;
  wire [5:0] h_cnt;
  fault_history u_hist (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(hist_push),
    .push_fault(last_r),
    .push_time(stamp_r),
    .sel(hsel_r),
    .rd_fault(h_flt),
    .rd_time(h_tim),
    .count_r(h_cnt)
  );

  // first set bit at or after start, wrapping; none gives F_NONE
  function [3:0] first_set;
    input [`NFAULT-1:0] v;
    input [3:0] start;
    integer k;
    integer j;
    begin
      first_set = `F_NONE;
      for (k = `NFAULT - 1; k >= 0; k = k - 1) begin
        j = (start + k) % `NFAULT;
        if (v[j]) begin
          first_set = j[3:0];
        end
      end
    end
  endfunction

  // recall mode and blink index
  reg [3:0] rc_idx_r;
  wire blk_done;
  wire blk_led;
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_d_r <= 1'b0;
      rcl_act_r <= 1'b0;
      rcl_act_d_r <= 1'b0;
      rc_idx_r <= `F_NONE;
    end else begin
      en_d_r <= en;
      rcl_act_d_r <= rcl_act_r;
      if (en) begin
        rcl_act_r <= 1'b0;
      end else if (in_r[`I_RCL] && !disp_r) begin
        rcl_act_r <= 1'b1;
      end
      if (rcl_act_r && !rcl_act_d_r) begin
        rc_idx_r <= first_set(last_r, 4'h0);
      end else if (rcl_act_r && blk_done) begin
        rc_idx_r <= first_set(last_r, rc_idx_r + 4'h1);
      end
    end
  end

  // live code is lowest set fault
  wire [3:0] live_idx = first_set(flt_r, 4'h0);
  wire [3:0] show_idx = rcl_act_r ? rc_idx_r : live_idx;
  wire show_fast = show_idx <= `F_FAST_LAST;
  wire [3:0] cnt4 = show_fast ? show_idx + 4'h1 : show_idx - `F_FAST_LAST;
  // mode change restarts the train so no code is cut into another
  wire blk_run = !disp_r && (rcl_act_r == rcl_act_d_r) && (show_idx != `F_NONE)
    && (rcl_act_r || any) && !blk_done;
  blink_seq #(
    .HALF_FAST(HALF_FAST_CYC),
    .HALF_SLOW(HALF_SLOW_CYC),
    .PAUSE(PAUSE_CYC)
  ) u_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(blk_run),
    .fast(show_fast),
    .count(cnt4[2:0]),
    .led_r(blk_led),
    .done_r(blk_done)
  );

  // ready delay counter
  reg [31:0] rdy_cnt_r;
  always @(posedge aclk) begin
    if (!aresetn || !en || any) begin
      rdy_cnt_r <= 32'h0;
    end else if (rdy_cnt_r < READY_CYC) begin
      rdy_cnt_r <= rdy_cnt_r + 32'h1;
    end
  end

  // indicators and contacts
  always @(posedge aclk) begin
    if (!aresetn) begin
      ready_contact_r <= 1'b0;
      run_permit_r <= 1'b0;
      led_red_r <= 1'b1;
      led_yellow_r <= 1'b0;
      led_green_r <= 1'b1;
    end else begin
      ready_contact_r <= en && !any && (rdy_cnt_r >= READY_CYC);
      run_permit_r <= en && !any;
      led_yellow_r <= in_r[`I_RA] && en && !any;
      led_green_r <= 1'b1;
      if (disp_r) begin
        led_red_r <= any || !en;
      end else if (rcl_act_r) begin
        led_red_r <= (last_r != {`NFAULT{1'b0}}) ? blk_led : 1'b1;
      end else if (any) begin
        led_red_r <= blk_led;
      end else begin
        led_red_r <= !en;
      end
    end
  end

  // energy totals
  reg [31:0] e_life_r;
  reg [31:0] e_user_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      e_life_r <= 32'h0;
      e_user_r <= 32'h0;
    end else begin
      e_life_r <= e_life_r + {31'h0, energy_tick};
      // user total reset; a tick in the same cycle survives
      e_user_r <= (erst_r ? 32'h0 : e_user_r) + {31'h0, energy_tick};
    end
  end

  // bus write: address and data in either order, response after both
  reg [7:0] wa_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  wire do_wr = !awready && !wready && !bvalid;
  wire wa_ok = (wa_r == `A_CTRL) || (wa_r == `A_STAT) || (wa_r == `A_LAST)
    || (wa_r == `A_HSEL) || (wa_r == `A_HFLT) || (wa_r == `A_HTIM)
    || (wa_r == `A_HCNT) || (wa_r == `A_ELIF) || (wa_r == `A_EUSR)
    || (wa_r == `A_UPT);
  always @(posedge aclk) begin
    erst_r <= 1'b0;
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      wa_r <= 8'h00;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      disp_r <= 1'b0;
      hsel_r <= 6'h0;
    end else begin
      if (awvalid && awready) begin
        wa_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd_r <= wdata;
        ws_r <= wstrb;
        wready <= 1'b0;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wa_ok ? `RESP_OKAY : `RESP_SLVERR;
        awready <= 1'b1;
        wready <= 1'b1;
        if (wa_r == `A_CTRL && ws_r[0]) begin
          disp_r <= wd_r[`C_DISP];
          erst_r <= wd_r[`C_ERST];
        end
        if (wa_r == `A_HSEL && ws_r[0]) begin
          hsel_r <= wd_r[5:0];
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read mux; unmapped addresses answer zero with an error
  reg [31:0] rd_v;
  reg rd_ok;
  always @* begin
    rd_v = 32'h0;
    rd_ok = 1'b1;
    case (araddr)
      `A_CTRL: rd_v = {31'h0, disp_r};
      `A_STAT: rd_v = {17'h0, led_red_r, rcl_act_r, ready_contact_r, en, flt_r};
      `A_LAST: rd_v = {21'h0, last_r};
      `A_HSEL: rd_v = {26'h0, hsel_r};
      `A_HFLT: rd_v = {21'h0, h_flt};
      `A_HTIM: rd_v = h_tim;
      `A_HCNT: rd_v = {26'h0, h_cnt};
      `A_ELIF: rd_v = e_life_r;
      `A_EUSR: rd_v = e_user_r;
      `A_UPT: rd_v = uptime_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_v;
      rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule // regen_fault_supervisor
`default_nettype wire

// *** tb/plant_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module plant_ctrl (
  input wire logic aclk,
  input wire logic want_en,
  input wire logic want_rcl,
  output logic enable_in = 1'b0,
  output logic recall_in = 1'b0
);
  always @(posedge aclk) begin
    enable_in <= want_en;
    recall_in <= want_rcl && !want_en && !enable_in;
  end
endmodule // plant_ctrl
`default_nettype wire

// *** tb/regen_sup_chk_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module regen_sup_chk #(
  parameter [31:0] PRECHARGE_CYC = 32'd200,
  parameter [31:0] READY_CYC = 32'd50
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fb_fail_in,
  input wire logic over_temp_in,
  input wire logic dc_over_in,
  input wire logic diff_over_in,
  input wire logic sync_lost_in,
  input wire logic sync_giveup_in,
  input wire logic drv_err_in,
  input wire logic [2:0] leg_oc_in,
  input wire logic phase_loss_in,
  input wire logic dc_under_in,
  input wire logic freq_fail_in,
  input wire logic enable_in,
  input wire logic recall_in,
  input wire logic regen_busy_in,
  input wire logic ready_contact_r,
  input wire logic run_permit_r,
  input wire logic led_red_r,
  input wire logic led_yellow_r,
  input wire logic led_green_r
);
  localparam int RDY_MAX = READY_CYC + 20;
  wire logic quiet;
  logic [31:0] en_cnt_r, up_cnt_r;
  // pin-level view; filter lag is absorbed by the windows below
  assign quiet = !(fb_fail_in | over_temp_in | dc_over_in | diff_over_in | sync_lost_in
    | sync_giveup_in | drv_err_in | (|leg_oc_in) | phase_loss_in | dc_under_in | freq_fail_in);
  // enabled-run length and uptime, uptime saturates
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_cnt_r <= 32'h0;
      up_cnt_r <= 32'h0;
    end else begin
      en_cnt_r <= enable_in ? en_cnt_r + 32'h1 : 32'h0;
      up_cnt_r <= (up_cnt_r > PRECHARGE_CYC + 32'h14) ? up_cnt_r : up_cnt_r + 32'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_quiet_en; (quiet && enable_in && up_cnt_r > PRECHARGE_CYC + 32'h14)[*8]; endsequence
  sequence s_dcov_pulse; dc_over_in[*6] ##1 !dc_over_in; endsequence
  property p_green; led_green_r; endproperty
  property p_yel_on; regen_busy_in[*8] |-> led_yellow_r; endproperty
  property p_yel_off; (!regen_busy_in)[*8] |-> !led_yellow_r; endproperty
  property p_red_solid;
    ready_contact_r ##1 (!enable_in && !recall_in && quiet)[*8] |-> ##2 led_red_r;
  endproperty
  property p_red_off; $rose(ready_contact_r) |-> !led_red_r; endproperty
  property p_ready_delay; $rose(ready_contact_r) |-> en_cnt_r >= READY_CYC; endproperty
  property p_fault_opens; (!quiet)[*6] |-> ##[0:8] !ready_contact_r; endproperty
  property p_permit; $fell(enable_in) |-> ##[1:12] !run_permit_r; endproperty
  property p_latch; s_dcov_pulse ##1 enable_in[*8] |-> !ready_contact_r; endproperty
  property p_selfclr; $fell(over_temp_in) ##1 s_quiet_en |-> ##[1:RDY_MAX] ready_contact_r; endproperty
  a_green: assert property (p_green) else $error("green led dark");
  a_yel_on: assert property (p_yel_on) else $error("yellow dark while busy");
  a_yel_off: assert property (p_yel_off) else $error("yellow lit while idle");
  a_red_solid: assert property (p_red_solid) else $error("red not solid when off");
  a_red_off: assert property (p_red_off) else $error("red lit at ready");
  a_ready_delay: assert property (p_ready_delay) else $error("ready too early");
  a_fault_opens: assert property (p_fault_opens) else $error("ready held on fault");
  a_permit: assert property (p_permit) else $error("runs while disabled");
  a_latch: assert property (p_latch) else $error("overvoltage not held");
  a_selfclr: assert property (p_selfclr) else $error("overtemp not cleared");
endmodule // regen_sup_chk
bind regen_fault_supervisor regen_sup_chk #(.PRECHARGE_CYC(PRECHARGE_CYC),
  .READY_CYC(READY_CYC)) chk (.aclk(aclk), .aresetn(aresetn), .fb_fail_in(fb_fail_in),
  .over_temp_in(over_temp_in), .dc_over_in(dc_over_in), .diff_over_in(diff_over_in),
  .sync_lost_in(sync_lost_in), .sync_giveup_in(sync_giveup_in), .drv_err_in(drv_err_in),
  .leg_oc_in(leg_oc_in), .phase_loss_in(phase_loss_in), .dc_under_in(dc_under_in),
  .freq_fail_in(freq_fail_in), .enable_in(enable_in), .recall_in(recall_in),
  .regen_busy_in(regen_busy_in), .ready_contact_r(ready_contact_r),
  .run_permit_r(run_permit_r), .led_red_r(led_red_r), .led_yellow_r(led_yellow_r),
  .led_green_r(led_green_r));
`default_nettype wire

// *** tb/regen_fault_supervisor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "regen_sup_consts.vh"
module regen_fault_supervisor_tb;
  localparam int PRE = 200, RDY = 50, PAU = 40, HF = 5, HS = 15;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rng = 32'd4632;
  logic [12:0] cause = 13'h0;
  logic want_en = 1'b0, want_rcl = 1'b0, busy = 1'b0, tick = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, enable_in, recall_in;
  wire logic ready, permit, red, yellow, green;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int failures = 0, n_checks = 0, cyc = 0;
  int fb_of[13] = '{0, 1, 2, 3, 4, 4, 5, 6, 6, 6, 7, 8, 10};
  int lat[13] = '{1, 0, 1, 1, 0, 1, 1, 1, 1, 1, 0, 0, 1};
  // half-period toggle, 5 ns period
  always #2.5 aclk = ~aclk;
  regen_fault_supervisor #(.PRECHARGE_CYC(PRE), .READY_CYC(RDY), .PAUSE_CYC(PAU),
    .HALF_FAST_CYC(HF), .HALF_SLOW_CYC(HS), .SEC_CYC(100)) dut (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .fb_fail_in(cause[0]),
    .over_temp_in(cause[1]), .dc_over_in(cause[2]), .diff_over_in(cause[3]),
    .sync_lost_in(cause[4]), .sync_giveup_in(cause[5]), .drv_err_in(cause[6]),
    .leg_oc_in(cause[9:7]), .phase_loss_in(cause[10]), .dc_under_in(cause[11]),
    .freq_fail_in(cause[12]), .enable_in(enable_in), .recall_in(recall_in),
    .regen_busy_in(busy), .energy_tick(tick), .ready_contact_r(ready),
    .run_permit_r(permit), .led_red_r(red), .led_yellow_r(yellow), .led_green_r(green));
  plant_ctrl plant (.aclk(aclk), .want_en(want_en), .want_rcl(want_rcl),
    .enable_in(enable_in), .recall_in(recall_in));
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, generous against the expected few thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // both channels offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_d && awready) awvalid <= 1'b0;
      if (!aw_d && awready) aw_d = 1'b1;
      if (!w_d && wready) wvalid <= 1'b0;
      if (!w_d && wready) w_d = 1'b1;
    end while (!(aw_d && w_d && bvalid));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check("rresp", r, `RESP_OKAY);
    check("rdata", d & m, e);
  endtask
  task automatic waitrdy();
    for (int k = 0; k < RDY + 40 && ready !== 1'b1; k++) @(posedge aclk);
  endtask
  task automatic toggle();
    want_en <= 1'b0;
    tk(10);
    want_en <= 1'b1;
    tk(12);
  endtask
  // one code group: flash count and first on-width, delimited by long dark
  task automatic blink(input int g, output int n, output int w);
    int lo, hi;
    n = 0;
    w = 0;
    hi = 0;
    lo = g;
    while (lo < PAU - 5) begin
      @(posedge aclk);
      lo = (red === 1'b1) ? 0 : lo + 1;
    end
    lo = 0;
    while (n == 0 || lo < PAU - 5) begin
      @(posedge aclk);
      if (red === 1'b1) begin
        hi++;
        lo = 0;
      end else begin
        if (hi > 0 && w == 0) w = hi;
        if (hi > 0) n++;
        hi = 0;
        lo++;
      end
    end
  endtask
  // main sequence; mf is the bench's own fault model
  initial begin
    int n, w, n2, w2, mf, e;
    logic [31:0] d;
    logic [1:0] r;
    tk(12);
    aresetn <= 1'b1;
    check("green", green, 1'b1);
    tk(1);
    rd_chk(`A_STAT, 32'h7FF, 32'h200);
    tk(PRE);
    rd_chk(`A_STAT, 32'h7FF, 32'h0);
    want_en <= 1'b1;
    tk(RDY - 10);
    check("ready early", ready, 1'b0);
    waitrdy();
    check("ready", ready, 1'b1);
    want_en <= 1'b0;
    tk(12);
    check("red disabled", red, 1'b1);
    check("ready disabled", ready, 1'b0);
    want_en <= 1'b1;
    waitrdy();
    check("red running", red, 1'b0);
    mf = 0;
    for (int i = 0; i < 13; i++) begin
      cause[i] <= 1'b1;
      tk(12 + int'(rnd() % 8));
      mf = mf | (1 << fb_of[i]);
      check("ready on fault", ready, 1'b0);
      rd_chk(`A_STAT, 32'h7FF, mf);
      blink(0, n, w);
      check("flashes", n, fb_of[i] < 5 ? fb_of[i] + 1 : fb_of[i] - 4);
      check("flash width", w, fb_of[i] < 5 ? HF : HS);
      cause[i] <= 1'b0;
      tk(12);
      if (!lat[i]) mf = mf & ~(1 << fb_of[i]);
      rd_chk(`A_STAT, 32'h7FF, mf);
      if (!lat[i]) waitrdy();
      if (!lat[i]) check("ready back", ready, 1'b1);
      toggle();
      mf = mf & 32'h400;
      rd_chk(`A_STAT, 32'h7FF, mf);
    end
    aresetn <= 1'b0;
    tk(12);
    aresetn <= 1'b1;
    tk(PRE + 20);
    rd_chk(`A_STAT, 32'h7FF, 32'h0);
    waitrdy();
    cause[0] <= 1'b1;
    cause[6] <= 1'b1;
    tk(10);
    cause[0] <= 1'b0;
    cause[6] <= 1'b0;
    want_en <= 1'b0;
    want_rcl <= 1'b1;
    tk(12);
    rd_chk(`A_LAST, 32'h7FF, 32'h21);
    blink(0, n, w);
    blink(PAU - 5, n2, w2);
    check("recall flashes", n + n2, 2);
    check("recall widths", w + w2, HF + HS);
    want_en <= 1'b1;
    want_rcl <= 1'b0;
    waitrdy();
    check("ready after recall", ready, 1'b1);
    axi_wr(`A_CTRL, 32'h1, r);
    check("bresp", r, `RESP_OKAY);
    cause[2] <= 1'b1;
    tk(8);
    cause[2] <= 1'b0;
    tk(12);
    e = 0;
    for (int k = 0; k < 20; k++) begin
      @(posedge aclk);
      if (red === 1'b1) e++;
    end
    check("red steady", e, 20);
    toggle();
    rd_chk(`A_HCNT, 32'hFF, 32'h1);
    axi_wr(`A_HSEL, 32'h0, r);
    rd_chk(`A_HFLT, 32'h7FF, 32'h4);
    e = 3 + int'(rnd() % 10);
    busy <= 1'b1;
    tick <= 1'b1;
    tk(e);
    tick <= 1'b0;
    tk(12);
    check("yellow", yellow, 1'b1);
    busy <= 1'b0;
    rd_chk(`A_EUSR, 32'hFFFFFFFF, e);
    axi_wr(`A_CTRL, 32'h3, r);
    rd_chk(`A_EUSR, 32'hFFFFFFFF, 32'h0);
    rd_chk(`A_ELIF, 32'hFFFFFFFF, e);
    rd_chk(`A_CTRL, 32'h3, 32'h1);
    axi_rd(8'h40, d, r);
    check("unmapped rresp", r, `RESP_SLVERR);
    check("unmapped rdata", d, 32'h0);
    axi_wr(8'h40, 32'h5, r);
    check("unmapped bresp", r, `RESP_SLVERR);
    print_verdict();
  end
endmodule // regen_fault_supervisor_tb
`default_nettype wire
